// *** rtl/sgpc_policy_bank.sv ***
// Purpose: Global policy control registers and the frame decisions they steer
// Assumes: Register port and frame attributes are synchronous to clock_i
// Notes: Decisions answer one cycle after the request; reads answer one cycle after rd_en_i
//
// Contract
// - Aggressive back-off bit at 1 selects the non-standard half-duplex back-off, default 0.
// - Port-VLAN discard at 1 blocks every boundary crossing, at 0 only known unicast may cross.
// - Port mirroring is permitted only while the port-VLAN discard bit is set.
// - Storm exclusion at 1 regulates only broadcast, at 0 also any frame with DA[40] set.
// - Back-pressure style bit selects carrier-sense at 1 (default) and collision at 0.
// - Fair mode at 1 drops from the non-flow-controlled port, at 0 throttles the other.
// - With no-excessive-collision-drop at 0 a frame with 16 or more collisions is dropped.
// - Huge-frame bit at 1 accepts up to 1916 bytes regardless of the legal-size bit.
// - Otherwise the limit is 1536, or 1522 tagged and 1518 untagged with legal-size at 1.
// - The 802.1Q VLAN enable bit turns VLAN mode on at 1, default off.
// - IGMP snoop at 1 sends every IGMP frame to the processor port, default off.
// - Bits 5 and 4 of the VLAN and snoop register are read-only and read as 0.
`timescale 1ns/10ps
module sgpc_policy_bank
    import sgpc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    // Register port
    input wire logic [sgpc_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [sgpc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [sgpc_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    // Frame decision request
    input wire logic frame_valid_i,
    input wire logic [sgpc_pkg::LEN_W-1:0] frame_length_i,
    input wire logic frame_tagged_i,
    input wire logic [47:0] frame_da_i,
    input wire logic frame_crosses_pvlan_i,
    input wire logic frame_known_unicast_i,
    input wire logic frame_is_igmp_i,
    // Transmit collision report
    input wire logic coll_valid_i,
    input wire logic [sgpc_pkg::COLL_W-1:0] coll_count_i,
    // Congestion between a flow-controlled and a non-flow-controlled source
    input wire logic mixed_congest_i,
    // Decision answer
    output logic decision_valid_o,
    output logic drop_oversize_o,
    output logic drop_pvlan_o,
    output logic storm_count_o,
    output logic igmp_to_cpu_o,
    output logic coll_drop_o,
    output logic drop_nonfc_port_o,
    output logic throttle_fc_port_o,
    // Level controls to MAC and forwarding logic
    output logic aggr_backoff_o,
    output logic bp_carrier_sense_o,
    output logic mirror_allowed_o,
    output logic vlan_mode_o
);
    import sgpc_pkg::*;

    logic [7:0] mac_ctrl_reg;
    logic [7:0] mac_ctrl_next;
    logic [7:0] fwd_ctrl_reg;
    logic [7:0] fwd_ctrl_next;
    logic [7:0] vsn_ctrl_reg;
    logic [7:0] vsn_ctrl_next;

    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    logic dec_valid_reg;
    logic dec_valid_next;
    logic oversize_reg;
    logic oversize_next;
    logic pvlan_drop_reg;
    logic pvlan_drop_next;
    logic storm_reg;
    logic storm_next;
    logic igmp_reg;
    logic igmp_next;
    logic coll_drop_reg;
    logic coll_drop_next;
    logic nonfc_drop_reg;
    logic nonfc_drop_next;
    logic fc_throttle_reg;
    logic fc_throttle_next;

    logic [3:0] level_reg;
    logic [3:0] level_next;

    logic chk_oversize;
    logic chk_storm;

    sgpc_frame_check u_frame_check (
        .huge_frame_i(fwd_ctrl_reg[HUGE_FRAME_BIT]),
        .legal_size_i(fwd_ctrl_reg[LEGAL_SIZE_BIT]),
        .mcast_storm_excl_i(fwd_ctrl_reg[MCAST_STORM_EXCL_BIT]),
        .tagged_i(frame_tagged_i),
        .length_i(frame_length_i),
        .da_i(frame_da_i),
        .limit_o(),
        .oversize_o(chk_oversize),
        .storm_class_o(chk_storm)
    );

    // Register writes; all other offsets ignore writes
    always_comb begin
        mac_ctrl_next = mac_ctrl_reg;
        fwd_ctrl_next = fwd_ctrl_reg;
        vsn_ctrl_next = vsn_ctrl_reg;
        if (wr_en_i) begin
            if (addr_i == MAC_GLOBAL_CONTROL_OFS) begin
                mac_ctrl_next = wr_data_i;
            end else if (addr_i == FORWARDING_POLICY_CONTROL_OFS) begin
                // Reserved bit 0 is stored as written; software keeps it at 0
                fwd_ctrl_next = wr_data_i;
            end else if (addr_i == VLAN_SNOOP_CONTROL_OFS) begin
                vsn_ctrl_next = wr_data_i & VLAN_SNOOP_CONTROL_WMASK;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mac_ctrl_reg <= MAC_GLOBAL_CONTROL_RST;
            fwd_ctrl_reg <= FORWARDING_POLICY_CONTROL_RST;
            vsn_ctrl_reg <= VLAN_SNOOP_CONTROL_RST;
        end else begin
            mac_ctrl_reg <= mac_ctrl_next;
            fwd_ctrl_reg <= fwd_ctrl_next;
            vsn_ctrl_reg <= vsn_ctrl_next;
        end
    end

    // Register reads; unmapped offsets read as zero
    always_comb begin
        rd_valid_next = rd_en_i;
        rd_data_next = rd_data_reg;
        if (rd_en_i) begin
            if (addr_i == MAC_GLOBAL_CONTROL_OFS) begin
                rd_data_next = mac_ctrl_reg;
            end else if (addr_i == FORWARDING_POLICY_CONTROL_OFS) begin
                rd_data_next = fwd_ctrl_reg;
            end else if (addr_i == VLAN_SNOOP_CONTROL_OFS) begin
                rd_data_next = vsn_ctrl_reg & VLAN_SNOOP_CONTROL_WMASK;
            end else begin
                rd_data_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // Frame decisions use the register values as they stand, so a write
    // applies to the very next request with no restart of the switch
    always_comb begin
        dec_valid_next = frame_valid_i;
        oversize_next = 1'b0;
        pvlan_drop_next = 1'b0;
        storm_next = 1'b0;
        igmp_next = 1'b0;
        if (frame_valid_i) begin
            oversize_next = chk_oversize;
            storm_next = chk_storm;
            // Known unicast may cross only with the discard bit cleared
            pvlan_drop_next = frame_crosses_pvlan_i
                && (fwd_ctrl_reg[PVLAN_DISCARD_BIT] || !frame_known_unicast_i);
            igmp_next = vsn_ctrl_reg[IGMP_SNOOP_BIT] && frame_is_igmp_i;
        end
    end

    // Excessive collisions and mixed flow-control congestion
    always_comb begin
        coll_drop_next = coll_valid_i && (coll_count_i >= EXCESS_COLL_LIMIT)
            && !fwd_ctrl_reg[NO_EXCOLL_DROP_BIT];
        nonfc_drop_next = mixed_congest_i && fwd_ctrl_reg[FAIR_MODE_BIT];
        fc_throttle_next = mixed_congest_i && !fwd_ctrl_reg[FAIR_MODE_BIT];
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            dec_valid_reg <= 1'b0;
            oversize_reg <= 1'b0;
            pvlan_drop_reg <= 1'b0;
            storm_reg <= 1'b0;
            igmp_reg <= 1'b0;
            coll_drop_reg <= 1'b0;
            nonfc_drop_reg <= 1'b0;
            fc_throttle_reg <= 1'b0;
        end else begin
            dec_valid_reg <= dec_valid_next;
            oversize_reg <= oversize_next;
            pvlan_drop_reg <= pvlan_drop_next;
            storm_reg <= storm_next;
            igmp_reg <= igmp_next;
            coll_drop_reg <= coll_drop_next;
            nonfc_drop_reg <= nonfc_drop_next;
            fc_throttle_reg <= fc_throttle_next;
        end
    end

    // Level controls, retimed so every output leaves from a flip-flop
    always_comb begin
        level_next[0] = mac_ctrl_reg[AGGR_BACKOFF_BIT];
        level_next[1] = fwd_ctrl_reg[BP_CARRIER_BIT];
        // Mirroring is only safe while boundary crossing is fully blocked
        level_next[2] = fwd_ctrl_reg[PVLAN_DISCARD_BIT];
        // VLAN mode relies on software having loaded the table first
        level_next[3] = vsn_ctrl_reg[VLAN_ENABLE_BIT];
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            level_reg <= 4'h6;
        end else begin
            level_reg <= level_next;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign decision_valid_o = dec_valid_reg;
    assign drop_oversize_o = oversize_reg;
    assign drop_pvlan_o = pvlan_drop_reg;
    assign storm_count_o = storm_reg;
    assign igmp_to_cpu_o = igmp_reg;
    assign coll_drop_o = coll_drop_reg;
    assign drop_nonfc_port_o = nonfc_drop_reg;
    assign throttle_fc_port_o = fc_throttle_reg;
    assign aggr_backoff_o = level_reg[0];
    assign bp_carrier_sense_o = level_reg[1];
    assign mirror_allowed_o = level_reg[2];
    assign vlan_mode_o = level_reg[3];
endmodule : sgpc_policy_bank

// *** rtl/sgpc_pkg.sv ***
// Purpose: Shared constants for the switch global policy control bank
// Assumes: 8-bit register index space, byte-wide registers
// Notes: Field positions are bit indices within each byte register
package sgpc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LEN_W = 11;
    localparam int unsigned COLL_W = 5;

    // Register indices
    localparam logic [7:0] MAC_GLOBAL_CONTROL_OFS = 8'h03;
    localparam logic [7:0] FORWARDING_POLICY_CONTROL_OFS = 8'h04;
    localparam logic [7:0] VLAN_SNOOP_CONTROL_OFS = 8'h05;

    // Reset values
    localparam logic [7:0] MAC_GLOBAL_CONTROL_RST = 8'h34;
    localparam logic [7:0] FORWARDING_POLICY_CONTROL_RST = 8'hf0;
    localparam logic [7:0] VLAN_SNOOP_CONTROL_RST = 8'h00;

    // Writable bits of the mixed register; bits 5,4,2,1 read as zero
    localparam logic [7:0] VLAN_SNOOP_CONTROL_WMASK = 8'hc9;

    // mac_global_control fields
    localparam int unsigned AGGR_BACKOFF_BIT = 0;

    // forwarding_policy_control fields
    localparam int unsigned PVLAN_DISCARD_BIT = 7;
    localparam int unsigned MCAST_STORM_EXCL_BIT = 6;
    localparam int unsigned BP_CARRIER_BIT = 5;
    localparam int unsigned FAIR_MODE_BIT = 4;
    localparam int unsigned NO_EXCOLL_DROP_BIT = 3;
    localparam int unsigned HUGE_FRAME_BIT = 2;
    localparam int unsigned LEGAL_SIZE_BIT = 1;
    localparam int unsigned FWD_RSVD_BIT = 0;

    // vlan_snoop_control fields
    localparam int unsigned VLAN_ENABLE_BIT = 7;
    localparam int unsigned IGMP_SNOOP_BIT = 6;

    // Destination address group bit
    localparam int unsigned DA_GROUP_BIT = 40;

    // Frame length limits in bytes, inclusive
    localparam logic [10:0] LEN_HUGE_MAX = 11'h077c;
    localparam logic [10:0] LEN_DEFAULT_MAX = 11'h0600;
    localparam logic [10:0] LEN_TAGGED_MAX = 11'h05f2;
    localparam logic [10:0] LEN_UNTAGGED_MAX = 11'h05ee;

    // Collision count at which a frame is abandoned
    localparam logic [4:0] EXCESS_COLL_LIMIT = 5'h10;
endpackage : sgpc_pkg

// *** rtl/sgpc_frame_check.sv ***
// Purpose: Per-frame length limit and storm class evaluation
// Assumes: Inputs stable in the cycle they are sampled by the caller
// Notes: Purely combinational; the caller registers the results
`timescale 1ns/10ps
module sgpc_frame_check
    import sgpc_pkg::*;
(
    input wire logic huge_frame_i,
    input wire logic legal_size_i,
    input wire logic mcast_storm_excl_i,
    input wire logic tagged_i,
    input wire logic [sgpc_pkg::LEN_W-1:0] length_i,
    input wire logic [47:0] da_i,
    output logic [sgpc_pkg::LEN_W-1:0] limit_o,
    output logic oversize_o,
    output logic storm_class_o
);
    always_comb begin
        if (huge_frame_i) begin
            limit_o = LEN_HUGE_MAX;
        end else if (!legal_size_i) begin
            limit_o = LEN_DEFAULT_MAX;
        end else if (tagged_i) begin
            limit_o = LEN_TAGGED_MAX;
        end else begin
            limit_o = LEN_UNTAGGED_MAX;
        end
        oversize_o = length_i > limit_o;
        // Broadcast always counts; group-addressed only when not excluded
        storm_class_o = (&da_i) || (!mcast_storm_excl_i && da_i[DA_GROUP_BIT]);
    end
endmodule : sgpc_frame_check

// *** bench/sgpc_policy_bank_chk.sv ***
// Purpose: Port-level checks for the policy bank
// Assumes: One clock, reset_i asynchronous and active high
// Notes: Register contents are hidden here, so outputs are tied to input history
`timescale 1ns/10ps
module sgpc_policy_bank_chk
    import sgpc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic rd_valid_o,
    input wire logic frame_valid_i,
    input wire logic decision_valid_o,
    input wire logic coll_valid_i,
    input wire logic [4:0] coll_count_i,
    input wire logic coll_drop_o,
    input wire logic mixed_congest_i,
    input wire logic drop_nonfc_port_o,
    input wire logic throttle_fc_port_o,
    input wire logic aggr_backoff_o,
    input wire logic bp_carrier_sense_o,
    input wire logic mirror_allowed_o,
    input wire logic vlan_mode_o
);
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    a_read_answer: assert property (rd_valid_o == $past(rd_en_i))
        else $error("read answer not one cycle after request");
    a_decision_lag: assert property (decision_valid_o == $past(frame_valid_i))
        else $error("decision not one cycle after frame request");
    a_coll_drop_cause: assert property (coll_drop_o |->
        $past(coll_valid_i) && $past(coll_count_i) >= EXCESS_COLL_LIMIT)
        else $error("collision drop without a count of sixteen");
    a_coll_low_keep: assert property (
        coll_valid_i && coll_count_i < EXCESS_COLL_LIMIT |=> !coll_drop_o)
        else $error("collision drop below sixteen");
    a_fair_exclusive: assert property (!(drop_nonfc_port_o && throttle_fc_port_o))
        else $error("drop and throttle together");
    a_fair_follow: assert property (
        (drop_nonfc_port_o || throttle_fc_port_o) == $past(mixed_congest_i))
        else $error("congestion answer does not follow request");
    a_levels_after_reset: assert property ($fell(reset_i) |->
        !aggr_backoff_o && bp_carrier_sense_o && mirror_allowed_o && !vlan_mode_o)
        else $error("control levels wrong after reset");
    a_vlan_write_lag: assert property (
        wr_en_i && addr_i == VLAN_SNOOP_CONTROL_OFS
        ##1 !(wr_en_i && addr_i == VLAN_SNOOP_CONTROL_OFS)
        |=> vlan_mode_o == $past(wr_data_i[7], 2))
        else $error("vlan mode level does not follow write");
    a_mirror_cause: assert property ($changed(mirror_allowed_o) |->
        $past(wr_en_i, 2) && $past(addr_i, 2) == FORWARDING_POLICY_CONTROL_OFS)
        else $error("mirror level changed without a write");
    a_backoff_cause: assert property ($changed(aggr_backoff_o) |->
        $past(wr_en_i, 2) && $past(addr_i, 2) == MAC_GLOBAL_CONTROL_OFS)
        else $error("back-off level changed without a write");
    c_read: cover property (rd_valid_o);
    c_coll_drop: cover property (coll_drop_o);
    c_drop_nonfc: cover property (drop_nonfc_port_o);
    c_throttle: cover property (throttle_fc_port_o);
endmodule : sgpc_policy_bank_chk
bind sgpc_policy_bank sgpc_policy_bank_chk sgpc_policy_bank_chk_i (
    .clock_i, .reset_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_valid_o, .frame_valid_i,
    .decision_valid_o, .coll_valid_i, .coll_count_i, .coll_drop_o, .mixed_congest_i,
    .drop_nonfc_port_o, .throttle_fc_port_o, .aggr_backoff_o, .bp_carrier_sense_o,
    .mirror_allowed_o, .vlan_mode_o
);

// *** bench/sgpc_policy_bank_tb.sv ***
// Purpose: Self-checking bench for the policy bank
// Assumes: Seeded random stimulus with corner lengths and addresses mixed in
// Notes: Software side keeps the reserved forwarding bit at zero
`timescale 1ns/10ps
module sgpc_policy_bank_tb;
    import sgpc_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
    logic [7:0] m03 = MAC_GLOBAL_CONTROL_RST, m04 = FORWARDING_POLICY_CONTROL_RST;
    logic [7:0] m05 = VLAN_SNOOP_CONTROL_RST;
    logic wr_en_i = 1'b0, rd_en_i = 1'b0, frame_valid_i = 1'b0, frame_tagged_i = 1'b0;
    logic coll_valid_i = 1'b0, frame_crosses_pvlan_i = 1'b0, frame_known_unicast_i = 1'b0;
    logic frame_is_igmp_i = 1'b0;
    logic mixed_congest_i = 1'b0, rd_valid_o, decision_valid_o, drop_oversize_o, drop_pvlan_o;
    logic storm_count_o, igmp_to_cpu_o, coll_drop_o, drop_nonfc_port_o, throttle_fc_port_o;
    logic aggr_backoff_o, bp_carrier_sense_o, mirror_allowed_o, vlan_mode_o;
    logic [10:0] frame_length_i = 11'h000;
    logic [47:0] frame_da_i = 48'h0000_0000_0000;
    logic [4:0] coll_count_i = 5'h00;
    logic [10:0] lens [8] = '{11'h077c, 11'h077d, 11'h0600, 11'h0601, 11'h05f2, 11'h05f3,
                              11'h05ee, 11'h05ef};
    int err_total = 0;
    int num_checks = 0;
    sgpc_policy_bank sgpc_policy_bank_i (
        .clock_i, .reset_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .rd_valid_o,
        .frame_valid_i, .frame_length_i, .frame_tagged_i, .frame_da_i, .frame_crosses_pvlan_i,
        .frame_known_unicast_i, .frame_is_igmp_i, .coll_valid_i, .coll_count_i,
        .mixed_congest_i, .decision_valid_o, .drop_oversize_o, .drop_pvlan_o, .storm_count_o,
        .igmp_to_cpu_o, .coll_drop_o, .drop_nonfc_port_o, .throttle_fc_port_o,
        .aggr_backoff_o, .bp_carrier_sense_o, .mirror_allowed_o, .vlan_mode_o
    );
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // Model keeps only writable bits, so masked bits are expected back as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_en_i <= 1'b1;
        wr_data_i <= d;
        @(posedge clock_i);
        wr_en_i <= 1'b0;
        if (a == 8'h03) m03 = d;
        if (a == 8'h04) m04 = d;
        if (a == 8'h05) m05 = d & 8'hc9;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clock_i);
        rd_en_i <= 1'b0;
        #1;
        check({7'h00, rd_valid_o, rd_data_o},
              {8'h01, a == 3 ? m03 : a == 4 ? m04 : a == 5 ? m05 : 8'h00});
    endtask : rd_chk
    task automatic lvl();
        check({aggr_backoff_o, bp_carrier_sense_o,
               mirror_allowed_o, vlan_mode_o}, {m03[0], m04[5], m04[7], m05[7]});
    endtask : lvl
    function automatic logic [15:0] exp_dec(logic [10:0] n, logic [47:0] da, logic [3:0] f);
        logic [10:0] lim;
        lim = m04[2] ? 11'h077c : !m04[1] ? 11'h0600 : f[3] ? 11'h05f2 : 11'h05ee;
        return {11'h000, 1'b1, n > lim, f[2] & (m04[7] | ~f[1]),
                &da | (~m04[6] & da[40]), f[0] & m05[6]};
    endfunction : exp_dec
    task automatic frame(input logic [10:0] n, input logic [47:0] da, input logic [3:0] f);
        @(posedge clock_i);
        frame_valid_i <= 1'b1;
        frame_length_i <= n;
        frame_da_i <= da;
        {frame_tagged_i, frame_crosses_pvlan_i, frame_known_unicast_i, frame_is_igmp_i} <= f;
        @(posedge clock_i);
        frame_valid_i <= 1'b0;
        #1;
        check({decision_valid_o, drop_oversize_o, drop_pvlan_o,
               storm_count_o, igmp_to_cpu_o}, exp_dec(n, da, f));
    endtask : frame
    initial begin
        logic [47:0] da;
        int s;
        void'($urandom(13077));
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        for (int a = 3; a < 7; a++) rd_chk(8'(a));
        lvl();
        $display("reset values test done");
        repeat (6) begin
            for (int a = 3; a < 7; a++) begin
                wr(8'(a), a == 4 ? 8'($urandom) & 8'hfe : 8'($urandom));
            end
            for (int a = 3; a < 7; a++) rd_chk(8'(a));
            lvl();
        end
        $display("register access test done");
        for (int i = 0; i < 80; i++) begin
            if (i % 6 == 0) wr(8'h04, 8'($urandom) & 8'hfe);
            // No VLAN table lives in this block, so enabling VLAN mode is always in order
            if (i % 6 == 3) wr(8'h05, 8'($urandom));
            s = $urandom % 10;
            da = {16'($urandom), 32'($urandom)};
            // Keep the broadcast case whole so the all-ones path is exercised
            if (i % 3 == 0) begin
                da = 48'hffff_ffff_ffff;
            end else begin
                da[40] = (i % 3 == 1);
            end
            frame(s < 8 ? lens[s] : 11'($urandom), da, 4'($urandom));
        end
        $display("frame decision test done");
        for (int e = 0; e < 2; e++) begin
            wr(8'h04, (m04 & 8'hf6) | (e == 1 ? 8'h08 : 8'h00));
            for (int c = 15; c < 18; c++) begin
                @(posedge clock_i);
                coll_valid_i <= 1'b1;
                coll_count_i <= c == 17 ? 5'h1f : 5'(c);
                @(posedge clock_i);
                coll_valid_i <= 1'b0;
                #1;
                check({15'h0000, coll_drop_o}, {15'h0000, e == 0 && c > 15});
            end
        end
        $display("collision test done");
        for (int f = 0; f < 2; f++) begin
            wr(8'h04, (m04 & 8'hee) | (f == 1 ? 8'h10 : 8'h00));
            @(posedge clock_i);
            mixed_congest_i <= 1'b1;
            @(posedge clock_i);
            mixed_congest_i <= 1'b0;
            #1;
            check({14'h0000, drop_nonfc_port_o, throttle_fc_port_o}, f == 1 ? 16'h0002 : 16'h0001);
        end
        $display("fair mode test done");
        summarize();
    end
    // Run needs a few hundred cycles; the margin covers a stalled answer
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        summarize();
    end
endmodule : sgpc_policy_bank_tb
